// ### hdl/asq_params.svh
/*
 * Constants for the actuator state query responder: request and reply field
 * values, operating condition codes and member limits.
 * Assumes inclusion by bare name from the design modules.
 */
`ifndef ASQ_PARAMS_SVH
`define ASQ_PARAMS_SVH

// Reserved actuator handles
`define ASQ_HANDLE_RSVD_LO 16'h0000
`define ASQ_HANDLE_RSVD_HI 16'hFFFF

// Result codes
`define ASQ_RC_SUCCESS 8'h00
`define ASQ_RC_ERROR 8'h01
`define ASQ_RC_BAD_HANDLE 8'h80

// Member count limits
`define ASQ_MEMBERS_MIN 8'h01
`define ASQ_MEMBERS_MAX 8'h08

// Operating condition codes
`define ASQ_COND_ENABLED_IDLE 8'h00
`define ASQ_COND_ENABLED_CHANGE 8'h01

// Default Unknown encoding of a state set
`define ASQ_UNKNOWN_DEFAULT 8'h00

// Bytes per state record
`define ASQ_RECORD_BYTES 2'h3

`endif

// ### hdl/asq_pkg.sv
/*
 * Types for the actuator state query responder.
 * Assumes the constants header is on the include path.
 */
package asq_pkg;
    // Reply sequencer states
    typedef enum logic [2:0] {
        ASQ_IDLE,
        ASQ_LOOKUP,
        ASQ_SEND_CODE,
        ASQ_SEND_COUNT,
        ASQ_SEND_RECORD
    } asq_state_t;
endpackage

// ### hdl/asq_record_fmt.sv
/*
 * Formats one three-byte state record for a member actuator.
 * Assumes the member's condition and values are stable while selected.
 */
`timescale 1ns/100ps
`include "asq_params.svh"

module asq_record_fmt (
    // Member state in
    input wire logic [7:0] condition,
    input wire logic [7:0] requested_value,
    input wire logic [7:0] present_value,
    input wire logic [7:0] unknown_code,
    // Byte select, 0 to 2
    input wire logic [1:0] byte_sel,
    // Formatted byte
    output logic [7:0] record_byte
);
    // Condition decode
    wire logic changing;
    wire logic idle;
    wire logic enabled;
    wire logic [7:0] pending_byte;
    wire logic [7:0] current_byte;

    assign changing = (condition == `ASQ_COND_ENABLED_CHANGE);
    assign idle = (condition == `ASQ_COND_ENABLED_IDLE);
    assign enabled = changing | idle;

    // In-flight request shown while changing, else present value R6
    // Values are hidden unless the member is enabled R7 R8
    assign pending_byte = !enabled ? unknown_code : (changing ? requested_value : present_value);
    assign current_byte = enabled ? present_value : unknown_code;

    // Record order: condition, pending, current R5
    assign record_byte = (byte_sel == 2'h0) ? condition :
                         (byte_sel == 2'h1) ? pending_byte : current_byte;
endmodule // asq_record_fmt

// ### hdl/asq_responder.sv
/*
 * Actuator state query responder: takes a 16-bit handle and streams the
 * reply bytes (result code, member count, one record per member).
 * Assumes a handle table and member state supplied on plain ports by the
 * owning logic, inputs synchronous to clk, and a sink that may stall.
 */
// Notes on behaviour
// R1: Request is a 16-bit handle, two reserved
// R2: Reply opens with result code, 0x80 bad
// R3: Member count follows, between one and eight
// R4: Up to eight members, records in order
// R5: Record is condition, pending, current bytes
// R6: Pending shows request while changing, else current
// R7: Pending is Unknown unless enabled condition
// R8: Current is Unknown unless enabled condition
// R9: Requester ignores values when not enabled
// R10: Value encodings follow each member's state set
// R11: Error reply ends after result code
`timescale 1ns/100ps
`include "asq_params.svh"

module asq_responder #(
    parameter int NUM_HANDLES = 4,
    parameter int MAX_MEMBERS = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Request
    input wire logic req_valid,
    input wire logic [15:0] actuator_handle,
    output logic req_ready,
    // Handle table: handle value and member count per slot
    input wire logic [NUM_HANDLES*16-1:0] table_handle,
    input wire logic [NUM_HANDLES*8-1:0] table_members,
    input wire logic internal_fault,
    // Member state, indexed by slot and member offset
    input wire logic [NUM_HANDLES*MAX_MEMBERS*8-1:0] member_condition,
    input wire logic [NUM_HANDLES*MAX_MEMBERS*8-1:0] member_requested,
    input wire logic [NUM_HANDLES*MAX_MEMBERS*8-1:0] member_present,
    input wire logic [NUM_HANDLES*MAX_MEMBERS*8-1:0] member_unknown,
    // Reply byte stream
    output logic [7:0] rsp_data,
    output logic rsp_valid,
    output logic rsp_last,
    input wire logic rsp_ready
);
    localparam int SLOT_W = (NUM_HANDLES > 1) ? $clog2(NUM_HANDLES) : 1;

    // Sequencer state
    asq_pkg::asq_state_t state_reg, state_next;
    logic [15:0] handle_reg; // Captured request handle
    logic [SLOT_W-1:0] slot_reg; // Matching slot
    logic [7:0] count_reg; // Member count of the reply
    logic [7:0] code_reg; // Result code of the reply
    logic [2:0] member_reg; // Member offset being sent
    logic [1:0] byte_reg; // Byte within the record
    logic [7:0] rsp_data_reg;
    logic rsp_valid_reg;
    logic rsp_last_reg;
    logic req_ready_reg;
    // A request counts only when offered while ready; one raised during a
    // reply waits for ready instead of being swallowed mid-reply R1
    wire logic req_take = req_valid && req_ready_reg;

    // Table search over all slots
    logic hit;
    logic [SLOT_W-1:0] hit_slot;
    always_comb begin
        hit = 1'b0;
        hit_slot = '0;
        for (int i = NUM_HANDLES - 1; i >= 0; i--) begin
            if (table_handle[i*16 +: 16] == handle_reg) begin
                hit = 1'b1;
                hit_slot = SLOT_W'(i);
            end
        end
    end

    // Reserved handles never name an actuator R1
    wire logic reserved = (handle_reg == `ASQ_HANDLE_RSVD_LO) ||
                          (handle_reg == `ASQ_HANDLE_RSVD_HI);
    wire logic [7:0] slot_members = table_members[hit_slot*8 +: 8];
    // A slot with an out-of-range count is treated as absent R3
    wire logic count_ok = (slot_members >= `ASQ_MEMBERS_MIN) &&
                          (slot_members <= `ASQ_MEMBERS_MAX) &&
                          (int'(slot_members) <= MAX_MEMBERS);
    wire logic found = hit && !reserved && count_ok;
    wire logic [7:0] lookup_code = !found ? `ASQ_RC_BAD_HANDLE :
                                   (internal_fault ? `ASQ_RC_ERROR : `ASQ_RC_SUCCESS); // R2

    // Member fields of the selected record; each member carries its own
    // Unknown code since encodings belong to its state set R10
    wire logic [31:0] sel_base = (32'(slot_reg) * 32'(MAX_MEMBERS) + 32'(member_reg)) *
                                 32'h0000_0008;
    wire logic [7:0] rec_byte;
    asq_record_fmt u_fmt (
        .condition(member_condition[sel_base +: 8]),
        .requested_value(member_requested[sel_base +: 8]),
        .present_value(member_present[sel_base +: 8]),
        .unknown_code(member_unknown[sel_base +: 8]),
        .byte_sel(byte_reg),
        .record_byte(rec_byte)
    );

    // Output slot is free when empty or being taken this cycle
    wire logic out_free = !rsp_valid_reg || rsp_ready;
    wire logic last_member = ({5'h00, member_reg} == count_reg - 8'h01);
    wire logic last_byte = (byte_reg == `ASQ_RECORD_BYTES - 2'h1);

    // Next state and output byte selection
    logic [7:0] data_next;
    logic valid_next;
    logic last_next;
    always_comb begin
        state_next = state_reg;
        data_next = rsp_data_reg;
        valid_next = rsp_valid_reg && !rsp_ready;
        last_next = rsp_last_reg;
        case (state_reg)
            asq_pkg::ASQ_IDLE: begin
                if (req_take) begin
                    state_next = asq_pkg::ASQ_LOOKUP;
                end
            end
            asq_pkg::ASQ_LOOKUP: begin
                state_next = asq_pkg::ASQ_SEND_CODE;
            end
            asq_pkg::ASQ_SEND_CODE: begin
                if (out_free) begin
                    // Code leads the reply R2
                    data_next = code_reg;
                    valid_next = 1'b1;
                    // Error reply stops after the code R11
                    last_next = (code_reg != `ASQ_RC_SUCCESS);
                    state_next = last_next ? asq_pkg::ASQ_IDLE : asq_pkg::ASQ_SEND_COUNT;
                end
            end
            asq_pkg::ASQ_SEND_COUNT: begin
                if (out_free) begin
                    data_next = count_reg; // R3
                    valid_next = 1'b1;
                    last_next = 1'b0;
                    state_next = asq_pkg::ASQ_SEND_RECORD;
                end
            end
            asq_pkg::ASQ_SEND_RECORD: begin
                if (out_free) begin
                    data_next = rec_byte; // R5
                    valid_next = 1'b1;
                    last_next = last_member && last_byte;
                    if (last_next) begin
                        state_next = asq_pkg::ASQ_IDLE;
                    end
                end
            end
            default: begin
                state_next = asq_pkg::ASQ_IDLE;
            end
        endcase
    end

    // Sequencer and output registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= asq_pkg::ASQ_IDLE;
            rsp_data_reg <= 8'h00;
            rsp_valid_reg <= 1'b0;
            rsp_last_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            rsp_data_reg <= data_next;
            rsp_valid_reg <= valid_next;
            rsp_last_reg <= last_next;
        end
    end

    // Request ready only while idle and no reply pending; registered so it
    // drops the cycle after a request is taken
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            req_ready_reg <= 1'b0;
        end else begin
            // The last byte may still wait in the output stage after the
            // sequencer is idle, so ready also waits for it to be taken
            req_ready_reg <= (state_next == asq_pkg::ASQ_IDLE) && !valid_next && !req_take;
        end
    end

    // Request capture and lookup result
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            handle_reg <= 16'h0000;
            slot_reg <= '0;
            code_reg <= 8'h00;
            count_reg <= 8'h00;
        end else if (state_reg == asq_pkg::ASQ_IDLE && req_take) begin
            handle_reg <= actuator_handle; // R1
        end else if (state_reg == asq_pkg::ASQ_LOOKUP) begin
            slot_reg <= hit_slot;
            code_reg <= lookup_code;
            count_reg <= slot_members;
        end
    end

    // Record walk in offset order R4
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            member_reg <= 3'h0;
            byte_reg <= 2'h0;
        end else if (state_reg != asq_pkg::ASQ_SEND_RECORD) begin
            member_reg <= 3'h0;
            byte_reg <= 2'h0;
        end else if (out_free) begin
            byte_reg <= last_byte ? 2'h0 : byte_reg + 2'h1;
            if (last_byte) begin
                member_reg <= member_reg + 3'h1;
            end
        end
    end

    assign rsp_data = rsp_data_reg;
    assign rsp_valid = rsp_valid_reg;
    assign rsp_last = rsp_last_reg;
    assign req_ready = req_ready_reg;
endmodule // asq_responder

// ### tb/asq_responder_props.sv
/*
 * Checker for the actuator state query responder reply stream.
 * Assumes it is bound to asq_responder and sees only its ports.
 */
`timescale 1ns/100ps
module asq_responder_props (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Request
    input wire logic req_valid,
    input wire logic [15:0] actuator_handle,
    input wire logic req_ready,
    // Reply stream
    input wire logic [7:0] rsp_data,
    input wire logic rsp_valid,
    input wire logic rsp_last,
    input wire logic rsp_ready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [4:0] idx_reg; // Bytes taken in this reply
    logic [7:0] num_reg; // Member count seen in this reply
    wire take = req_valid && req_ready;
    wire beat = rsp_valid && rsp_ready;
    // Byte position; a new request restarts it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            idx_reg <= 5'h0;
            num_reg <= 8'h00;
        end else if (take) begin
            idx_reg <= 5'h0;
        end else if (beat) begin
            idx_reg <= idx_reg + 5'h1;
            if (idx_reg == 5'h1) num_reg <= rsp_data;
        end
    end
    sequence s_take;
        req_valid && req_ready;
    endsequence
    sequence s_bad_reply;
        rsp_valid && rsp_data == 8'h80 && rsp_last;
    endsequence
    AST_TAKE_BUSY: assert property (s_take |-> ##[1:2] !req_ready)
        else $error("req_ready stayed high after a taken request");
    AST_FIRST: assert property (s_take |-> ##[1:4] rsp_valid)
        else $error("no reply byte after a taken request");
    AST_RESERVED: assert property (s_take ##0 (actuator_handle == 16'h0000 ||
        actuator_handle == 16'hFFFF) |-> ##[1:4] s_bad_reply)
        else $error("reserved handle not answered with a lone bad code");
    AST_HOLD: assert property (rsp_valid && !rsp_ready |=>
        rsp_valid && $stable(rsp_data) && $stable(rsp_last))
        else $error("reply byte changed while stalled");
    AST_ERR_LAST: assert property (rsp_valid && idx_reg == 5'h0 &&
        rsp_data != 8'h00 |-> rsp_last)
        else $error("error reply went on past the code");
    AST_COUNT: assert property (rsp_valid && idx_reg == 5'h1 |->
        rsp_data inside {[8'h01:8'h08]})
        else $error("member count out of range");
    AST_LEN: assert property (rsp_valid && rsp_last && idx_reg >= 5'h2 |->
        int'(idx_reg) == 1 + 3 * int'(num_reg))
        else $error("record count does not match member count");
    AST_BUSY: assert property (rsp_valid |-> !req_ready)
        else $error("request offered while a reply runs");
    AST_BACK: assert property (beat && rsp_last |-> ##[1:3] req_ready)
        else $error("responder did not return to idle");
endmodule // asq_responder_props

bind asq_responder asq_responder_props asq_responder_props_inst (.clk(clk),
    .rst_b(rst_b), .req_valid(req_valid), .actuator_handle(actuator_handle),
    .req_ready(req_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
    .rsp_last(rsp_last), .rsp_ready(rsp_ready));

// ### tb/asq_sink.sv
/*
 * Requester model: takes reply bytes, optionally stalling.
 * Assumes one clock shared with the responder.
 */
`timescale 1ns/100ps
module asq_sink (
    // Clock and stream
    input wire logic clk,
    input wire logic [7:0] rsp_data,
    input wire logic rsp_valid,
    input wire logic rsp_last,
    input wire logic stall,
    output logic rsp_ready
);
    logic [7:0] got[$]; // Bytes taken
    int n_last = 0; // Replies ended
    logic tog = 1'b0;
    // Stalling drops ready every other cycle, so holds are exercised
    always @(negedge clk) begin
        tog <= !tog;
        rsp_ready <= !stall || tog;
    end
    // Kept raw; the caller compares values of non-enabled members against their unknown codes
    always @(posedge clk) begin
        if (rsp_valid && rsp_ready) begin
            got.push_back(rsp_data);
            if (rsp_last) n_last++;
        end
    end
endmodule // asq_sink

// ### tb/tb_top.sv
/*
 * Testbench for asq_responder with a handle table on plain ports.
 * Assumes the checker binds itself and asq_sink takes the reply.
 */
`timescale 1ns/100ps
module tb_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic req_valid = 1'b0;
    logic [15:0] actuator_handle = 16'h0000;
    logic req_ready, rsp_valid, rsp_last, rsp_ready;
    logic stall = 1'b0;
    logic fault = 1'b0;
    logic [7:0] rsp_data;
    // Slot 2 and 3 hold illegal counts 0 and 9
    logic [63:0] t_hdl = {16'h0404, 16'h0303, 16'h0202, 16'h0101};
    logic [31:0] t_num = {8'h09, 8'h00, 8'h01, 8'h08};
    logic [255:0] m_cnd, m_req, m_pre, m_unk;
    logic [7:0] exp_q[$];
    int miscompares = 0;
    int n_compared = 0;
    asq_responder asq_responder_inst (.clk(clk), .rst_b(rst_b),
        .req_valid(req_valid), .actuator_handle(actuator_handle),
        .req_ready(req_ready), .table_handle(t_hdl), .table_members(t_num),
        .internal_fault(fault), .member_condition(m_cnd),
        .member_requested(m_req), .member_present(m_pre),
        .member_unknown(m_unk), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
        .rsp_last(rsp_last), .rsp_ready(rsp_ready));
    asq_sink asq_sink_inst (.clk(clk), .rsp_data(rsp_data),
        .rsp_valid(rsp_valid), .rsp_last(rsp_last), .stall(stall),
        .rsp_ready(rsp_ready));
    initial forever #2.5 clk = !clk;
    // Conditions cycle idle, changing, disabled; unknown code per member
    initial begin
        for (int i = 0; i < 32; i++) begin
            m_cnd[i*8+:8] = (i % 3 == 0) ? 8'h00 : (i % 3 == 1) ? 8'h01 : 8'h02;
            m_req[i*8+:8] = 8'h40 + i[7:0];
            m_pre[i*8+:8] = 8'h20 + i[7:0];
            m_unk[i*8+:8] = 8'hE0 + i[7:0];
        end
    end
    task chk8(input string what, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    // Expected success reply for slot s
    task exp_ok(input int s);
        logic [7:0] c, p, u;
        exp_q = {8'h00, t_num[s*8+:8]};
        for (int m = 0; m < t_num[s*8+:8]; m++) begin
            c = m_cnd[(s*8+m)*8+:8];
            p = m_pre[(s*8+m)*8+:8];
            u = m_unk[(s*8+m)*8+:8];
            exp_q.push_back(c);
            exp_q.push_back(c == 8'h01 ? m_req[(s*8+m)*8+:8] : c == 8'h00 ? p : u);
            exp_q.push_back(c <= 8'h01 ? p : u);
        end
    endtask
    // Request held until taken, then the whole reply compared
    task run(input logic [15:0] h, input string name);
        int k, n0;
        k = 0;
        n0 = asq_sink_inst.n_last;
        asq_sink_inst.got.delete();
        @(negedge clk);
        req_valid = 1'b1;
        actuator_handle = h;
        // Ready is looked at mid-cycle, so the next rising edge takes the request
        while (req_ready !== 1'b1 && k < 50) begin
            @(negedge clk);
            k++;
        end
        @(posedge clk);
        @(negedge clk);
        req_valid = 1'b0;
        actuator_handle = ~h;
        while (asq_sink_inst.n_last == n0 && k < 200) begin
            @(negedge clk);
            k++;
        end
        // A reply that never ends counts as a mismatch here
        chk8("replies ended", 8'h01, 8'(asq_sink_inst.n_last - n0));
        chk8("length", 8'(exp_q.size()), 8'(asq_sink_inst.got.size()));
        for (int i = 0; i < exp_q.size() && i < asq_sink_inst.got.size(); i++) begin
            chk8("reply byte", exp_q[i], asq_sink_inst.got[i]);
        end
        $display("test %s done", name);
    endtask
    task t_full;
        exp_ok(0);
        run(16'h0101, "eight members");
    endtask
    task t_one_stall;
        stall = 1'b1;
        exp_ok(1);
        run(16'h0202, "one member stalled");
        stall = 1'b0;
    endtask
    task t_bad;
        logic [15:0] hs[5];
        hs = '{16'h0000, 16'hFFFF, 16'h0505, 16'h0303, 16'h0404};
        foreach (hs[i]) begin
            exp_q = {8'h80};
            run(hs[i], "bad handle");
        end
    endtask
    task t_fault;
        fault = 1'b1;
        exp_q = {8'h01};
        run(16'h0101, "generic error");
        fault = 1'b0;
    endtask
    task stop_test;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        t_full();
        t_one_stall();
        t_bad();
        t_fault();
        t_full();
        stop_test();
    end
    // Whole run needs well under 2000 cycles
    initial begin
        #20000;
        miscompares++;
        stop_test();
    end
endmodule // tb_top
